/* rsst_defines.svh */
`ifndef RSST_DEFINES_SVH
`define RSST_DEFINES_SVH

// Register offsets
`define RSST_OFS_TRIM 8'h1B
`define RSST_OFS_SRC 8'h1D

// Field positions in the trim register
`define RSST_TRIM_CTRL_BIT 7
`define RSST_TRIM_FIELD_MSB 5
`define RSST_TRIM_FIELD_LSB 0

// Field positions in the source control register
`define RSST_SRC_FORCE_BIT 0
`define RSST_SRC_SELEXT_BIT 1
`define RSST_SRC_VALID_BIT 2
`define RSST_SRC_STALE_BIT 3

// Reset values: hardware trim in charge, field all ones, auto source
`define RSST_TRIM_RST 8'hBF
`define RSST_SRC_RST 8'h00

// Hardware default trim code, 2 pF in 0.25 pF steps
`define RSST_TRIM_DEFAULT 6'h08
// Fixed on-chip load, 13 pF in 0.25 pF steps
`define RSST_LOAD_FIXED 7'h34

// Calibration run time in clk_sys cycles
`define RSST_CAL_CYCLES 16

`endif

/* rsst_pkg.sv */
package rsst_pkg;

    // Calibration sequencer states
    typedef enum logic [1:0] {
        CAL_WAIT_REF,
        CAL_RUN,
        CAL_DONE
    } rsst_cal_state_t;

    // One preset entry: frequencies in units of 100 Hz
    typedef struct packed {
        logic known;
        logic outKnown;
        logic [31:0] vcoFreq;
        logic [31:0] outFreq;
    } rsst_preset_t;

endpackage : rsst_pkg

/* rsst_ctrl_if.sv */
`timescale 1ns/10ps
interface rsst_ctrl_if;
    logic [7:0] trimWord;
    logic [5:0] trimCode;
    logic [6:0] loadCap;
    logic forceXtal;
    logic refPresent;
    logic xtalPresent;
    logic selExt;
    logic xtalEn;
    logic refValid;

    modport trim (input trimWord, output trimCode, output loadCap);
    modport src (input forceXtal, input refPresent, input xtalPresent,
                 output selExt, output xtalEn, output refValid);
    modport top (output trimWord, input trimCode, input loadCap,
                 output forceXtal, output refPresent, output xtalPresent,
                 input selExt, input xtalEn, input refValid);
endinterface : rsst_ctrl_if

/* rsst_trim.sv */
`timescale 1ns/10ps
`include "rsst_defines.svh"
module rsst_trim (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Control carrier
    rsst_ctrl_if.trim ctl
);
    logic regCtrl;
    logic [5:0] trimCode_d;
    logic [5:0] trimCode_q;

    // Register field only while the control bit is low
    assign regCtrl = ~ctl.trimWord[`RSST_TRIM_CTRL_BIT];
    assign trimCode_d = regCtrl ?
        ctl.trimWord[`RSST_TRIM_FIELD_MSB:`RSST_TRIM_FIELD_LSB] :
        `RSST_TRIM_DEFAULT; // RQ5

    // Reset restores the 2 pF default, giving 15 pF total
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trimCode_q <= `RSST_TRIM_DEFAULT; // RQ3
        end else if (ce) begin
            trimCode_q <= trimCode_d;
        end
    end

    // Linear quarter-pF steps above the fixed part
    assign ctl.trimCode = trimCode_q; // RQ4
    assign ctl.loadCap = `RSST_LOAD_FIXED + {1'b0, trimCode_q}; // RQ4
endmodule : rsst_trim

/* rsst_srcsel.sv */
`timescale 1ns/10ps
module rsst_srcsel (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Control carrier
    rsst_ctrl_if.src ctl
);
    logic selExt_d;
    logic selExt_q;
    logic xtalEn_q;
    logic refValid_d;
    logic refValid_q;

    // External input wins unless the crystal is forced
    assign selExt_d = ctl.refPresent & ~ctl.forceXtal; // RQ7 RQ9
    assign refValid_d = selExt_d ? ctl.refPresent : ctl.xtalPresent; // RQ10

    // Re-evaluated every enabled cycle, so any input change shows next edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            selExt_q <= 1'b0;
            xtalEn_q <= 1'b1;
            refValid_q <= 1'b0;
        end else if (ce) begin
            selExt_q <= selExt_d; // RQ12
            xtalEn_q <= ~selExt_d; // RQ7 RQ12
            refValid_q <= refValid_d;
        end
    end

    assign ctl.selExt = selExt_q;
    assign ctl.xtalEn = xtalEn_q;
    assign ctl.refValid = refValid_q;
endmodule : rsst_srcsel

/* rsst_top.sv */
// Contract
// (RQ1) Preset code 110011 gives VCO 3468.75 MHz and output 693.75 MHz.
// (RQ2) Preset code 110001 gives VCO 3452.846 MHz.
// (RQ3) After reset the variable crystal load is 2 pF, 15 pF total.
// (RQ4) Six-bit trim field sets load linearly, 0.25 pF per code step.
// (RQ5) Trim field drives the load only while the control bit is zero.
// (RQ6) Trim field resets to all ones, 15.75 pF.
// (RQ7) A clock seen on the external input selects it, crystal off.
// (RQ8) Crystal-force bit resets to zero, external preference active.
// (RQ9) Crystal-force bit set keeps crystal selected regardless of detector.
// (RQ10) Pick source from monitor; calibrate only once a valid reference exists.
// (RQ11) The controller requests recalibration after changing preset pins.
// (RQ12) Source select and crystal enable are registered, re-evaluated continually.
`timescale 1ns/10ps
`include "rsst_defines.svh"
module rsst_top #(
    parameter int CAL_CYCLES = `RSST_CAL_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Preset selection pins
    input wire logic preset_code_bit5,
    input wire logic preset_code_bit4,
    input wire logic preset_code_bit3,
    input wire logic preset_code_bit2,
    input wire logic preset_code_bit1,
    input wire logic preset_code_bit0,
    // Reference monitor
    input wire logic refPresent,
    input wire logic xtalPresent,
    // Register port from the serial engine
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Calibration request from the serial engine
    input wire logic calRequest,
    // Reference control outputs
    output logic selExt,
    output logic xtalEn,
    output logic refValid,
    output logic [5:0] xtalTrimCode,
    output logic [6:0] xtalLoadQuarterPf,
    // Synthesis settings
    output logic presetKnown,
    output logic presetOutKnown,
    output logic [31:0] vcoFreq,
    output logic [31:0] outFreq,
    // Calibration status
    output logic calStart,
    output logic calBusy,
    output logic calDone,
    output logic presetStale
);
    // Refuse a calibration time the counter cannot hold
    if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal
        $error("CAL_CYCLES out of range");
    end

    rsst_ctrl_if ctl ();

    // Preset decode, frequencies in units of 100 Hz
    function automatic rsst_pkg::rsst_preset_t presetDecode(input logic [5:0] code);
        rsst_pkg::rsst_preset_t p;
        p = '0;
        // Codes whose output is a ratio carry the VCO setting only
        case (code)
            6'h31: begin
                p.known = 1'b1;
                p.vcoFreq = 32'h020EDCCC; // 3452.846 MHz
            end
            6'h32: begin
                p.known = 1'b1;
                p.vcoFreq = 32'h021115E6; // 3467.415 MHz
            end
            6'h33: begin
                p = {1'b1, 1'b1, 32'h02114A0C, 32'h0069DB9C};
            end
            6'h34: begin
                p.known = 1'b1;
                p.vcoFreq = 32'h02134F78; // 3481.996 MHz
            end
            6'h36: begin
                p.known = 1'b1;
                p.vcoFreq = 32'h021BAACE; // 3536.763 MHz
            end
            6'h37: begin
                p = {1'b1, 1'b1, 32'h0222ACAC, 32'h006D55BC};
            end
            6'h38: begin
                p = {1'b1, 1'b1, 32'h02245CDC, 32'h006DAC2C};
            end
            6'h39: begin
                p = {1'b1, 1'b1, 32'h02251D20, 32'h006DD2A0};
            end
            6'h3A: begin
                p = {1'b1, 1'b1, 32'h023ABB9E, 32'h00722585};
            end
            6'h3B: begin
                p = {1'b1, 1'b1, 32'h023C3460, 32'h007270E0};
            end
            6'h3C: begin
                p = {1'b1, 1'b1, 32'h02514300, 32'h0076A700};
            end
            6'h3D: begin
                p = {1'b1, 1'b1, 32'h0252C37E, 32'h0076F3E6};
            end
            6'h3E: begin
                p = {1'b1, 1'b1, 32'h02540BE4, 32'h00773594};
            end
            default: begin
                p = '0;
            end
        endcase
        return p;
    endfunction : presetDecode

    // Address match, used by both write and read paths
    function automatic logic addrHit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : addrHit

    logic [5:0] presetCode;
    rsst_pkg::rsst_preset_t presetNow;
    logic wrTrim;
    logic wrSrc;
    logic hitTrim;
    logic hitSrc;
    logic [7:0] rdMux;
    logic [7:0] srcStatus;
    logic [7:0] trimReg_q;
    logic forceXtal_q;
    logic [7:0] regRdData_q;
    logic regRdValid_q;
    rsst_pkg::rsst_preset_t preset_q;
    rsst_pkg::rsst_cal_state_t calState_q;
    rsst_pkg::rsst_cal_state_t calState_d;
    logic [15:0] calCnt_q;
    logic [15:0] calCnt_d;
    logic calStart_q;
    logic calLaunch;
    logic [5:0] calCode_q;

    // Pins gathered into one code, bit 5 first
    assign presetCode = {preset_code_bit5, preset_code_bit4, preset_code_bit3,
                         preset_code_bit2, preset_code_bit1, preset_code_bit0};
    assign presetNow = presetDecode(presetCode); // RQ1 RQ2

    // Settings are registered so pin glitches between clock edges never reach the synthesizer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            preset_q <= '0;
        end else if (ce) begin
            preset_q <= presetNow; // RQ1 RQ2
        end
    end

    // Register decode
    assign hitTrim = addrHit(regAddr, `RSST_OFS_TRIM);
    assign hitSrc = addrHit(regAddr, `RSST_OFS_SRC);
    assign wrTrim = regWr & hitTrim;
    assign wrSrc = regWr & hitSrc;

    // Trim register: field resets to all ones, hardware default in charge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trimReg_q <= `RSST_TRIM_RST; // RQ6
        end else if (ce && wrTrim) begin
            trimReg_q <= regWrData & 8'hBF;
        end
    end

    // Crystal-force bit, cleared so the external input is preferred
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            forceXtal_q <= 1'b0; // RQ8
        end else if (ce && wrSrc) begin
            forceXtal_q <= regWrData[`RSST_SRC_FORCE_BIT];
        end
    end

    // Source register reads back live status beside the force bit
    // Status bits are read-only, so writes to them are dropped
    assign srcStatus = {4'h0, presetStale, ctl.refValid, ctl.selExt, forceXtal_q};
    assign rdMux = hitTrim ? trimReg_q : (hitSrc ? srcStatus : 8'h00);

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdData_q <= 8'h00;
            regRdValid_q <= 1'b0;
        end else if (ce) begin
            regRdValid_q <= regRd;
            if (regRd) begin
                regRdData_q <= rdMux;
            end
        end
    end

    // Carrier hookup
    assign ctl.trimWord = trimReg_q;
    assign ctl.forceXtal = forceXtal_q;
    assign ctl.refPresent = refPresent;
    assign ctl.xtalPresent = xtalPresent;

    rsst_trim u_trim (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .ctl(ctl)
    );

    rsst_srcsel u_src (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .ctl(ctl)
    );

    // Calibration: wait for a valid reference, then run a fixed time.
    // A request restarts it; the device cannot tell a pin change was meant.
    assign calLaunch = (calState_q == rsst_pkg::CAL_WAIT_REF) && ctl.refValid; // RQ10

    always_comb begin
        calState_d = calState_q;
        calCnt_d = calCnt_q;
        case (calState_q)
            rsst_pkg::CAL_WAIT_REF: begin
                if (ctl.refValid) begin
                    calState_d = rsst_pkg::CAL_RUN; // RQ10
                    calCnt_d = 16'(CAL_CYCLES - 1);
                end
            end
            rsst_pkg::CAL_RUN: begin
                if (calCnt_q == 16'h0000) begin
                    calState_d = rsst_pkg::CAL_DONE;
                end else begin
                    calCnt_d = calCnt_q - 16'h0001;
                end
            end
            rsst_pkg::CAL_DONE: begin
                calState_d = rsst_pkg::CAL_DONE;
            end
            default: begin
                calState_d = rsst_pkg::CAL_WAIT_REF;
            end
        endcase
        if (calRequest) begin
            calState_d = rsst_pkg::CAL_WAIT_REF; // RQ11
            calCnt_d = 16'h0000;
        end
    end

    // A request in the launch cycle suppresses the start pulse
    // Sequencer registers and the code latched at launch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            calState_q <= rsst_pkg::CAL_WAIT_REF;
            calCnt_q <= 16'h0000;
            calStart_q <= 1'b0;
            calCode_q <= 6'h00;
        end else if (ce) begin
            calState_q <= calState_d;
            calCnt_q <= calCnt_d;
            calStart_q <= calLaunch & ~calRequest;
            if (calLaunch) begin
                calCode_q <= presetCode;
            end
        end
    end

    // Pins moved since the last calibration: a recalibration is owed
    logic presetStale_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            presetStale_q <= 1'b0;
        end else if (ce) begin
            presetStale_q <= (calState_q != rsst_pkg::CAL_WAIT_REF) &&
                             (presetCode != calCode_q); // RQ11
        end
    end

    // Outputs
    assign regRdData = regRdData_q;
    assign regRdValid = regRdValid_q;
    assign selExt = ctl.selExt;
    assign xtalEn = ctl.xtalEn;
    assign refValid = ctl.refValid;
    assign xtalTrimCode = ctl.trimCode;
    assign xtalLoadQuarterPf = ctl.loadCap;
    assign presetKnown = preset_q.known;
    assign presetOutKnown = preset_q.outKnown;
    assign vcoFreq = preset_q.vcoFreq;
    assign outFreq = preset_q.outFreq;
    assign calStart = calStart_q;
    assign calBusy = (calState_q == rsst_pkg::CAL_RUN);
    assign calDone = (calState_q == rsst_pkg::CAL_DONE);
    assign presetStale = presetStale_q;
endmodule : rsst_top

/* rsst_top_checker.sv */
`timescale 1ns/10ps
module rsst_top_checker #(
    parameter int CAL_CYCLES = 16
) (
    // Clock and control
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic calRequest,
    // Reference monitor
    input wire logic refPresent,
    input wire logic xtalPresent,
    // Register writes
    input wire logic regWr,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    // Watched outputs
    input wire logic selExt,
    input wire logic xtalEn,
    input wire logic refValid,
    input wire logic [5:0] xtalTrimCode,
    input wire logic [6:0] xtalLoadQuarterPf,
    input wire logic calStart,
    input wire logic calBusy,
    input wire logic calDone
);
    logic forceQ;
    logic [7:0] trimQ;
    logic [16:0] busyLen;
    // Shadow of the two registers, built from the write strobes
    wire wrSrc = ce && regWr && regAddr == 8'h1D;
    wire wrTrim = ce && regWr && regAddr == 8'h1B;
    wire extWant = refPresent && !forceQ;
    wire [5:0] trimWant = trimQ[7] ? 6'h08 : trimQ[5:0];

    // Shadow registers and busy length counter; frozen edges do not count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            forceQ <= 1'b0;
            trimQ <= 8'hBF;
            busyLen <= 17'h00000;
        end else begin
            if (wrSrc)
                forceQ <= regWrData[0];
            if (wrTrim)
                trimQ <= {regWrData[7], 1'b0, regWrData[5:0]};
            if (!calBusy)
                busyLen <= 17'h00000;
            else if (ce)
                busyLen <= busyLen + 17'h00001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    crystal_resonator_pins_comp_a: assert property (xtalEn == !selExt)
        else $error("crystal enable is not the inverse of source select");
    ext_select_a: assert property (!$past(rst) && $past(ce) |-> selExt == $past(extWant))
        else $error("source select does not follow detector and force bit");
    ref_valid_a: assert property (!$past(rst) && $past(ce) |->
        refValid == ($past(extWant) || $past(xtalPresent)))
        else $error("reference valid does not match selected source");
    cal_start_a: assert property (calStart |-> $past(refValid) ##1 !calStart)
        else $error("calibration launched without a valid reference");
    cal_length_a: assert property ($fell(calBusy) && !$past(calRequest) && !$past(rst)
        |-> calDone && busyLen == CAL_CYCLES)
        else $error("calibration run length wrong");
    cal_restart_a: assert property (ce && calRequest |=> !calBusy && !calDone)
        else $error("recalibration request not honoured");
    trim_apply_a: assert property (!$past(rst) && $past(ce) |-> xtalTrimCode == $past(trimWant))
        else $error("applied trim code wrong");
    load_sum_a: assert property (xtalLoadQuarterPf == 7'h34 + {1'b0, xtalTrimCode})
        else $error("total load is not fixed part plus trim");
endmodule : rsst_top_checker

/* rsst_ref_model.sv */
`timescale 1ns/10ps
module rsst_ref_model #(
    parameter int START = 3
) (
    // Clock and scenario controls
    input wire logic clk_sys,
    input wire logic extOn,
    input wire logic xtalFit,
    // Crystal enable from the block
    input wire logic xtalEn,
    // Presence seen by the monitor
    output logic refPresent,
    output logic xtalPresent
);
    logic [3:0] runCnt = 4'h0;

    // External oscillator is seen as soon as it runs
    assign refPresent = extOn;
    assign xtalPresent = runCnt == 4'(START);

    // Crystal needs a few cycles to start and stops at once when disabled
    always @(posedge clk_sys) begin
        if (!xtalEn || !xtalFit)
            runCnt <= 4'h0;
        else if (runCnt < 4'(START))
            runCnt <= runCnt + 4'h1;
    end
endmodule : rsst_ref_model

/* tb_rsst_top.sv */
`timescale 1ns/10ps
module tb_rsst_top;
    // Stimulus and observed signals
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic regWr = 1'b0, regRd = 1'b0, calRequest = 1'b0, extOn = 1'b0, xtalFit = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [5:0] pins = 6'h00, xtalTrimCode;
    logic refPresent, xtalPresent, regRdValid, selExt, xtalEn, refValid;
    logic presetKnown, presetOutKnown, calStart, calBusy, calDone, presetStale;
    logic [6:0] xtalLoadQuarterPf;
    logic [31:0] vcoFreq, outFreq;
    int mismatches = 0;
    int check_count = 0;

    always #10 clk_sys = ~clk_sys;

    // Short calibration run keeps the regression brief
    rsst_top #(.CAL_CYCLES(4)) DUT (
        .clk_sys(clk_sys), .rst(rst), .ce(ce),
        .preset_code_bit5(pins[5]), .preset_code_bit4(pins[4]), .preset_code_bit3(pins[3]),
        .preset_code_bit2(pins[2]), .preset_code_bit1(pins[1]), .preset_code_bit0(pins[0]),
        .refPresent(refPresent), .xtalPresent(xtalPresent), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .calRequest(calRequest), .selExt(selExt), .xtalEn(xtalEn),
        .refValid(refValid), .xtalTrimCode(xtalTrimCode),
        .xtalLoadQuarterPf(xtalLoadQuarterPf), .presetKnown(presetKnown),
        .presetOutKnown(presetOutKnown), .vcoFreq(vcoFreq), .outFreq(outFreq),
        .calStart(calStart), .calBusy(calBusy), .calDone(calDone), .presetStale(presetStale)
    );
    rsst_ref_model refSrc (.clk_sys(clk_sys), .extOn(extOn), .xtalFit(xtalFit),
        .xtalEn(xtalEn), .refPresent(refPresent), .xtalPresent(xtalPresent));

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Ends just after an edge so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        // Valid stands for the one cycle after the strobe edge
        #1;
        chk(32'(regRdValid), 32'h1);
        chk(32'(regRdData), 32'(e));
    endtask : rd

    // Bounded wait; running out counts against the run
    task automatic waitDone();
        for (int i = 0; i < 60 && calDone !== 1'b1; i++)
            tick(1);
        chk(32'(calDone), 32'h1);
        if (calDone !== 1'b1)
            wrap_up();
    endtask : waitDone

    task automatic checkReset();
        rd(8'h1B, 8'hBF);
        rd(8'h1D, 8'h00);
        rd(8'h2A, 8'h00);
        chk(32'(xtalTrimCode), 32'h08);
        chk(32'(xtalLoadQuarterPf), 32'h3C);
        chk(32'(calBusy | calDone), 32'h0);
    endtask : checkReset

    task automatic checkTrim();
        wr(8'h1B, 8'h3F);
        tick(1);
        chk(32'(xtalTrimCode), 32'h3F);
        chk(32'(xtalLoadQuarterPf), 32'h73);
        wr(8'h1B, 8'h00);
        tick(1);
        chk(32'(xtalLoadQuarterPf), 32'h34);
        wr(8'h1B, 8'hC5);
        tick(1);
        chk(32'(xtalTrimCode), 32'h08);
        rd(8'h1B, 8'h85);
    endtask : checkTrim

    // Enable low must swallow a write entirely
    task automatic checkFreeze();
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(8'h1B, 8'h3F);
        tick(1);
        chk(32'(xtalTrimCode), 32'h08);
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(8'h1B, 8'h85);
    endtask : checkFreeze

    task automatic checkSource();
        @(posedge clk_sys);
        xtalFit <= 1'b1;
        waitDone();
        chk(32'(selExt), 32'h0);
        @(posedge clk_sys);
        extOn <= 1'b1;
        tick(2);
        chk(32'({selExt, xtalEn}), 32'h2);
        wr(8'h1D, 8'h01);
        tick(1);
        chk(32'({selExt, xtalEn}), 32'h1);
        tick(8);
        rd(8'h1D, 8'h05);
        wr(8'h1D, 8'h00);
        tick(1);
        chk(32'(selExt), 32'h1);
    endtask : checkSource

    task automatic checkPreset();
        @(posedge clk_sys);
        pins <= 6'h33;
        tick(2);
        chk(32'(presetKnown), 32'h1);
        chk(vcoFreq, 32'h0211_4A0C);
        chk(outFreq, 32'h0069_DB9C);
        chk(32'(presetStale), 32'h1);
        @(posedge clk_sys);
        calRequest <= 1'b1;
        @(posedge clk_sys);
        calRequest <= 1'b0;
        tick(1);
        chk(32'(calDone), 32'h0);
        waitDone();
        chk(32'(presetStale), 32'h0);
        @(posedge clk_sys);
        pins <= 6'h31;
        tick(2);
        chk(vcoFreq, 32'h020E_DCCC);
        chk(32'(presetOutKnown), 32'h0);
    endtask : checkPreset

    // Reset for sixteen cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        checkReset();
        checkTrim();
        checkFreeze();
        checkSource();
        checkPreset();
        wrap_up();
    end
endmodule : tb_rsst_top

bind rsst_top rsst_top_checker #(.CAL_CYCLES(CAL_CYCLES)) chkr (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .calRequest(calRequest),
    .refPresent(refPresent), .xtalPresent(xtalPresent), .regWr(regWr),
    .regAddr(regAddr), .regWrData(regWrData), .selExt(selExt), .xtalEn(xtalEn),
    .refValid(refValid), .xtalTrimCode(xtalTrimCode),
    .xtalLoadQuarterPf(xtalLoadQuarterPf), .calStart(calStart), .calBusy(calBusy),
    .calDone(calDone)
);
